// ==== src/gpa_pkg.sv ====
/*
  gpa_pkg: constants used by the port A block; its pin synchroniser uses none of them.
  Assumes the oscillator mode code is a static configuration value.
*/
package gpa_pkg;

  localparam int unsigned PORT_W = 8;
  localparam int unsigned ASEL_W = 5;
  localparam int unsigned CMP_W  = 3;
  localparam int unsigned OSC_W  = 4;
  localparam int unsigned SYNC_STAGES = 3;

  // pin positions
  localparam int unsigned PIN_A2 = 2;
  localparam int unsigned PIN_A4 = 4;
  localparam int unsigned PIN_A5 = 5;
  localparam int unsigned PIN_A6 = 6;
  localparam int unsigned PIN_A7 = 7;

  // analog select field: bits 3:0 map to pins a3..a0, bit 4 to pin a5
  localparam int unsigned ASEL_A5_BIT = 4;

  // reset values
  localparam logic [7:0] DIR_RST  = 8'hFF;
  localparam logic [7:0] HOLD_RST = 8'h00;
  localparam logic [4:0] ASEL_RST = 5'h1F;
  localparam logic [2:0] CMP_RST  = 3'h7;
  localparam logic [2:0] CMP_OFF  = 3'h7;
  localparam logic [1:0] DIV_RST  = 2'h0;

  // main oscillator mode codes
  localparam logic [3:0] OSC_LP_MODE                    = 4'h0;
  localparam logic [3:0] OSC_XT_MODE                    = 4'h1;
  localparam logic [3:0] OSC_HS_MODE                    = 4'h2;
  localparam logic [3:0] OSC_HS_PLL_MODE                = 4'h3;
  localparam logic [3:0] OSC_RESISTOR_CAP_OSC_MODE      = 4'h4;
  localparam logic [3:0] OSC_RESISTOR_CAP_IO_MODE       = 4'h5;
  localparam logic [3:0] OSC_EXT_CLOCK_MODE             = 4'h6;
  localparam logic [3:0] OSC_EXT_CLOCK_IO_MODE          = 4'h7;
  localparam logic [3:0] OSC_INTERNAL_OSC_IO_MODE       = 4'h8;
  localparam logic [3:0] OSC_INTERNAL_OSC_CLOCKOUT_MODE = 4'h9;

  // pin a6 is general I/O
  function automatic logic a6_io(input logic [3:0] mode);
    return (mode == OSC_RESISTOR_CAP_IO_MODE) || (mode == OSC_INTERNAL_OSC_IO_MODE) ||
           (mode == OSC_EXT_CLOCK_IO_MODE);
  endfunction

  // pin a6 carries the cycle clock
  function automatic logic a6_cycle_clock_output(input logic [3:0] mode);
    return (mode == OSC_RESISTOR_CAP_OSC_MODE) || (mode == OSC_INTERNAL_OSC_CLOCKOUT_MODE) ||
           (mode == OSC_EXT_CLOCK_MODE);
  endfunction

  // pin a7 is general I/O only when no external oscillator uses it
  function automatic logic a7_io(input logic [3:0] mode);
    return (mode == OSC_INTERNAL_OSC_IO_MODE) || (mode == OSC_INTERNAL_OSC_CLOCKOUT_MODE);
  endfunction

endpackage

// ==== src/gpa_pin_sync.sv ====
/*
  gpa_pin_sync: three-stage synchroniser with agreement filter per pin.
  Assumes pin levels are asynchronous to sys_clk_i.
*/
`timescale 1ns/1ps
module gpa_pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync2_ff;
  logic [WIDTH-1:0] sync3_ff;
  logic [WIDTH-1:0] level_ff;

  // stage chain; first stage feeds only the second
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_ff  <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      meta_ff  <= async_i;
      sync2_ff <= meta_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // per-bit accept once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          level_ff[gi] <= 1'b0;
        end else if (sync2_ff[gi] == sync3_ff[gi]) begin
          level_ff[gi] <= sync3_ff[gi];
        end
      end
    end
  endgenerate

  assign level_o = level_ff;

endmodule // gpa_pin_sync

// ==== src/gpa_port.sv ====
/*
  gpa_port: 8-bit bidirectional port A with direction, pin level and
  output hold registers, analog, comparator and oscillator pin sharing.
  Assumes software access arrives as same-clock write strobes, pins are
  resolved outside from pin_o / pin_oe_o, and osc_mode_i is static.
*/
`timescale 1ns/1ps
module gpa_port #(
  parameter int unsigned WIDTH = gpa_pkg::PORT_W
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_b_i,
  // software register access
  input  wire logic [7:0]                 wdata_i,
  input  wire logic                       dir_wr_i,
  input  wire logic                       port_wr_i,
  input  wire logic                       hold_wr_i,
  input  wire logic                       asel_wr_i,
  input  wire logic                       cmp_wr_i,
  output logic      [7:0]                 port_a_direction_o,
  output logic      [7:0]                 port_a_pin_levels_o,
  output logic      [7:0]                 port_a_output_hold_o,
  output logic      [gpa_pkg::ASEL_W-1:0] analog_select_control_o,
  output logic      [gpa_pkg::CMP_W-1:0]  comparator_config_o,
  // configuration and sharing peripherals
  input  wire logic [gpa_pkg::OSC_W-1:0]  osc_mode_i,
  input  wire logic                       comparator1_output_i,
  input  wire logic                       comparator2_output_i,
  input  wire logic                       cmp1_route_i,
  input  wire logic                       cmp2_route_i,
  input  wire logic                       comparator_ref_output_en_i,
  output logic                            timer0_ext_clock_o,
  output logic                            slave_select_o,
  output logic      [5:0]                 analog_connect_o,
  // pins
  input  wire logic [WIDTH-1:0]           pin_i,
  output logic      [WIDTH-1:0]           pin_o,
  output logic      [WIDTH-1:0]           pin_oe_o
);

  logic [WIDTH-1:0]           dir_ff;
  logic [WIDTH-1:0]           hold_ff;
  logic [gpa_pkg::ASEL_W-1:0] asel_ff;
  logic [gpa_pkg::CMP_W-1:0]  cmp_ff;
  logic [1:0]                 div_ff;
  logic [WIDTH-1:0]           pin_o_ff;
  logic [WIDTH-1:0]           pin_oe_ff;
  logic [7:0]                 dir_rd_ff;
  logic [7:0]                 lvl_rd_ff;
  logic [7:0]                 hold_rd_ff;
  logic                       t0_ff;
  logic                       ss_ff;
  logic [WIDTH-1:0]           sync_lvl;
  logic [WIDTH-1:0]           analog_en;
  logic [WIDTH-1:0]           port_pin;
  logic [WIDTH-1:0]           din_en;
  logic [WIDTH-1:0]           nxt_pin_o;
  logic [WIDTH-1:0]           nxt_pin_oe;
  logic                       cmp_on;
  logic                       a6_gpio;
  logic                       a6_clk;
  logic                       a7_gpio;
  logic                       clk_out;

  // oscillator mode decode
  assign a6_gpio = gpa_pkg::a6_io(osc_mode_i);
  assign a6_clk  = gpa_pkg::a6_cycle_clock_output(osc_mode_i);
  assign a7_gpio = gpa_pkg::a7_io(osc_mode_i);
  assign cmp_on  = (cmp_ff != gpa_pkg::CMP_OFF);
  assign clk_out = div_ff[1];

  // direction register
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dir_ff <= gpa_pkg::DIR_RST;
    end else if (dir_wr_i) begin
      dir_ff <= wdata_i[WIDTH-1:0];
    end
  end

  // output hold register, written through either register
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_ff <= gpa_pkg::HOLD_RST;
    end else if (port_wr_i || hold_wr_i) begin
      hold_ff <= wdata_i[WIDTH-1:0];
    end
  end

  // analog select control
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      asel_ff <= gpa_pkg::ASEL_RST;
    end else if (asel_wr_i) begin
      asel_ff <= wdata_i[gpa_pkg::ASEL_W-1:0];
    end
  end

  // comparator configuration
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmp_ff <= gpa_pkg::CMP_RST;
    end else if (cmp_wr_i) begin
      cmp_ff <= wdata_i[gpa_pkg::CMP_W-1:0];
    end
  end

  // cycle clock divider, quarter of the system clock
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_ff <= gpa_pkg::DIV_RST;
    end else begin
      div_ff <= div_ff + 2'h1;
    end
  end

  // analog use per pin; comparators also claim a0 to a3
  always_comb begin
    analog_en = '0;
    analog_en[3:0] = asel_ff[3:0] | {4{cmp_on}};
    analog_en[gpa_pkg::PIN_A5] = asel_ff[gpa_pkg::ASEL_A5_BIT];
    analog_en[gpa_pkg::PIN_A2] = analog_en[gpa_pkg::PIN_A2] | comparator_ref_output_en_i;
  end

  // pins that belong to the port at all
  always_comb begin
    port_pin = '1;
    port_pin[gpa_pkg::PIN_A6] = a6_gpio;
    port_pin[gpa_pkg::PIN_A7] = a7_gpio;
    port_pin[gpa_pkg::PIN_A2] = !comparator_ref_output_en_i;
  end

  assign din_en = port_pin & ~analog_en;

  gpa_pin_sync #(
    .WIDTH (WIDTH)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   (pin_i),
    .level_o   (sync_lvl)
  );

  // per-pin driver selection
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_pin
      always_comb begin
        nxt_pin_oe[gi] = port_pin[gi] & ~dir_ff[gi];
        nxt_pin_o[gi]  = hold_ff[gi] & nxt_pin_oe[gi];
        if (gi == gpa_pkg::PIN_A4 && cmp1_route_i && !dir_ff[gi]) begin
          nxt_pin_o[gi] = comparator1_output_i;
        end else if (gi == gpa_pkg::PIN_A5 && cmp2_route_i && !dir_ff[gi]) begin
          nxt_pin_o[gi] = comparator2_output_i;
        end else if (gi == gpa_pkg::PIN_A6 && a6_clk) begin
          nxt_pin_oe[gi] = 1'b1;
          nxt_pin_o[gi]  = clk_out;
        end
      end
    end
  endgenerate

  // registered pin drive
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_o_ff  <= '0;
      pin_oe_ff <= '0;
    end else begin
      pin_o_ff  <= nxt_pin_o;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  // register read values; non-port a6, a7 read zero
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dir_rd_ff  <= '0;
      lvl_rd_ff  <= '0;
      hold_rd_ff <= '0;
    end else begin
      dir_rd_ff  <= dir_ff & {2'h3 & {port_pin[7], port_pin[6]}, 6'h3F};
      lvl_rd_ff  <= sync_lvl & din_en;
      hold_rd_ff <= hold_ff & {port_pin[7], port_pin[6], 6'h3F};
    end
  end

  // shared digital inputs: timer0 clock on a4, slave select on a5
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      t0_ff <= 1'b0;
      ss_ff <= 1'b0;
    end else begin
      t0_ff <= sync_lvl[gpa_pkg::PIN_A4];
      ss_ff <= sync_lvl[gpa_pkg::PIN_A5];
    end
  end

  assign pin_o                   = pin_o_ff;
  assign pin_oe_o                = pin_oe_ff;
  assign port_a_direction_o      = dir_rd_ff;
  assign port_a_pin_levels_o     = lvl_rd_ff;
  assign port_a_output_hold_o    = hold_rd_ff;
  assign analog_select_control_o = asel_ff;
  assign comparator_config_o     = cmp_ff;
  assign timer0_ext_clock_o      = t0_ff;
  assign slave_select_o          = ss_ff;
  assign analog_connect_o        = analog_en[5:0];

  // checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  AST_DIR_INPUT_HIZ: assert property (
    dir_ff[0] |=> !pin_oe_o[0]
  ) else $error("input pin a0 is driven");

  AST_DIR_OUTPUT_DRIVE: assert property (
    (!dir_ff[1] && asel_ff[1]) |=> (pin_oe_o[1] && (pin_o[1] == $past(hold_ff[1])))
  ) else $error("output pin a1 not driving held value");

  AST_HOLD_READBACK: assert property (
    (hold_wr_i ##1 !(hold_wr_i || port_wr_i)) |=> (port_a_output_hold_o[5:0] == $past(wdata_i[5:0], 2))
  ) else $error("hold readback differs from written value");

  AST_PORT_WRITE_HOLD: assert property (
    port_wr_i |=> (hold_ff == $past(wdata_i))
  ) else $error("port write did not reach hold bits");

  AST_OSC_READ_ZERO: assert property (
    !a7_gpio |=> (port_a_pin_levels_o[7] == 1'b0 && port_a_output_hold_o[7] == 1'b0 &&
                  port_a_direction_o[7] == 1'b0)
  ) else $error("oscillator pin a7 bits not zero");

  AST_ANALOG_READ_ZERO: assert property (
    analog_en[0] |=> (port_a_pin_levels_o[0] == 1'b0)
  ) else $error("analog pin a0 reads nonzero");

  AST_CMP_OVERRIDE: assert property (
    (cmp1_route_i && !dir_ff[4]) |=> (pin_oe_o[4] && pin_o[4] == $past(comparator1_output_i))
  ) else $error("comparator 1 does not override a4");

  AST_COMPARATOR_REF_OUTPUT_OFF: assert property (
    comparator_ref_output_en_i |=> (!pin_oe_o[2] && port_a_pin_levels_o[2] == 1'b0)
  ) else $error("a2 digital active with reference output");

  AST_CYCLE_CLOCK_OUTPUT_TOGGLE: assert property (
    a6_clk [*5] |-> (pin_oe_o[6] && pin_o[6] != $past(pin_o[6], 2))
  ) else $error("a6 cycle clock not at quarter rate");

  AST_A7_EXT_OFF: assert property (
    !a7_gpio |=> !pin_oe_o[7]
  ) else $error("a7 driven in external oscillator mode");

  AST_A6_NONIO_OFF: assert property (
    (!a6_gpio && !a6_clk) |=> !pin_oe_o[6]
  ) else $error("a6 driven outside I/O modes");

  AST_A5_CMP_OVERRIDE: assert property (
    (cmp2_route_i && !dir_ff[5]) |=> (pin_oe_o[5] && pin_o[5] == $past(comparator2_output_i))
  ) else $error("comparator 2 does not override a5");

  AST_HOLD_DRIVE_ANALOG: assert property (
    (!dir_ff[0] && analog_en[0]) |=> (pin_oe_o[0] && pin_o[0] == $past(hold_ff[0]))
  ) else $error("analog output pin a0 not driving held value");

  AST_LEVEL_READ: assert property (
    (pin_i[4] [*2] ##3 din_en[4]) |=> port_a_pin_levels_o[4]
  ) else $error("pin a4 level not read back");

  AST_TIMER0_INPUT: assert property (
    pin_i[4] [*2] |-> ##4 timer0_ext_clock_o
  ) else $error("timer0 clock input does not follow a4");

  AST_SLAVE_SELECT: assert property (
    pin_i[5] [*2] |-> ##4 slave_select_o
  ) else $error("slave select does not follow a5");

  AST_RESET_DIR_INPUT: assert property (
    $rose(rst_b_i) |-> (dir_ff == gpa_pkg::DIR_RST && pin_oe_o == '0)
  ) else $error("pins not inputs after reset");

  AST_RESET_ANALOG: assert property (
    $rose(rst_b_i) |-> (asel_ff == gpa_pkg::ASEL_RST && cmp_ff == gpa_pkg::CMP_RST && !analog_en[4])
  ) else $error("analog setup wrong after reset");

  AST_CYCLE_CLOCK_OUTPUT_DIR_FREE: assert property (
    a6_clk |=> pin_oe_o[6]
  ) else $error("a6 cycle clock not driven");

  AST_A5_ANALOG_ZERO: assert property (
    analog_en[5] |=> (port_a_pin_levels_o[5] == 1'b0)
  ) else $error("analog pin a5 reads nonzero");

  AST_A6_READ_ZERO: assert property (
    !a6_gpio |=> (port_a_pin_levels_o[6] == 1'b0 && port_a_output_hold_o[6] == 1'b0 &&
                  port_a_direction_o[6] == 1'b0)
  ) else $error("oscillator pin a6 bits not zero");

  AST_DIR_WRITE: assert property (
    dir_wr_i |=> (dir_ff == $past(wdata_i[WIDTH-1:0]))
  ) else $error("direction write lost");

  AST_ANALOG_SELECT: assert property (
    asel_wr_i |=> (asel_ff == $past(wdata_i[gpa_pkg::ASEL_W-1:0]))
  ) else $error("analog select write lost");

  AST_A6_IO_DRIVE: assert property (
    (a6_gpio && !dir_ff[6]) |=> (pin_oe_o[6] && pin_o[6] == $past(hold_ff[6]))
  ) else $error("a6 not driving held value in I/O mode");

  AST_A7_IO_DRIVE: assert property (
    (a7_gpio && !dir_ff[7]) |=> (pin_oe_o[7] && pin_o[7] == $past(hold_ff[7]))
  ) else $error("a7 not driving held value in I/O mode");

  COV_DRIVE_OUT: cover property (dir_wr_i && wdata_i[0] == 1'b0 ##1 hold_wr_i ##2 pin_oe_o[0]);
  COV_CMP_ROUTE: cover property (cmp2_route_i && !dir_ff[5] ##1 pin_o[5]);
  COV_READ_LEVEL: cover property (!analog_en[4] && pin_i[4] ##5 port_a_pin_levels_o[4]);
  COV_CYCLE_CLOCK_OUTPUT: cover property (a6_clk ##4 pin_o[6]);
  COV_COMPARATOR_REF_OUTPUT: cover property (comparator_ref_output_en_i ##1 !pin_oe_o[2]);

endmodule // gpa_port

// ==== dv/gpa_board.sv ====
/*
  gpa_board: board circuitry on the port A pins.
  Assumes the bench gives a drive level for every pin; the board drives a pin
  only while the port has released it, so the wire never sees two drivers.
*/
`timescale 1ns/1ps
module gpa_board (
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] drive_i,
  output logic      [7:0] wire_o
);
  // port driver wins, released pins follow the board
  always_comb begin
    wire_o = (oe_i & pin_o_i) | (~oe_i & drive_i);
  end
endmodule // gpa_board

// ==== dv/bidir_port_with_pin_sharing_bench.sv ====
/*
  bidir_port_with_pin_sharing_bench: random self-checking bench for gpa_port.
  Assumes the gpa_board model on the pins and register writes as one-cycle strobes.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module bidir_port_with_pin_sharing_bench;
  logic       sys_clk_i = 1'b0;
  logic       rst_b_i   = 1'b0;
  logic [7:0] wdata_i   = 8'h00;
  logic       dir_wr_i  = 1'b0, port_wr_i = 1'b0, hold_wr_i = 1'b0, asel_wr_i = 1'b0, cmp_wr_i = 1'b0;
  logic [3:0] osc_mode_i = 4'h0;
  logic       c1 = 1'b0, c2 = 1'b0, r1 = 1'b0, r2 = 1'b0, ref_en = 1'b0;
  logic [7:0] brd = 8'h10;
  logic [7:0] dir_o, lvl_o, hold_o, pin_o, oe_o, pin_w;
  logic [4:0] asel_o;
  logic [2:0] cmp_o;
  logic       t0_o, ss_o;
  logic [5:0] acon_o;
  logic [7:0] dir = 8'hFF, hold = 8'h00;
  logic [4:0] asel = 5'h1F;
  logic [2:0] cmp = 3'h7;
  logic [3:0] hi;
  int         errors = 0, cmp_count = 0, k;
  int         seed = 32'h5a69862f;

  always #4 sys_clk_i = ~sys_clk_i;

  gpa_port DUT (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .wdata_i(wdata_i), .dir_wr_i(dir_wr_i),
    .port_wr_i(port_wr_i), .hold_wr_i(hold_wr_i), .asel_wr_i(asel_wr_i), .cmp_wr_i(cmp_wr_i),
    .port_a_direction_o(dir_o), .port_a_pin_levels_o(lvl_o), .port_a_output_hold_o(hold_o),
    .analog_select_control_o(asel_o), .comparator_config_o(cmp_o), .osc_mode_i(osc_mode_i),
    .comparator1_output_i(c1), .comparator2_output_i(c2), .cmp1_route_i(r1), .cmp2_route_i(r2),
    .comparator_ref_output_en_i(ref_en), .timer0_ext_clock_o(t0_o), .slave_select_o(ss_o),
    .analog_connect_o(acon_o), .pin_i(pin_w), .pin_o(pin_o), .pin_oe_o(oe_o)
  );

  gpa_board BRD (.pin_o_i(pin_o), .oe_i(oe_o), .drive_i(brd), .wire_o(pin_w));

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // one strobe: 0 dir, 1 port, 2 hold, 3 analog select, 4 comparator
  task automatic wr(input int s, input logic [7:0] d);
    @(negedge sys_clk_i);
    wdata_i = d;
    case (s)
      0: dir_wr_i = 1'b1;
      1: port_wr_i = 1'b1;
      2: hold_wr_i = 1'b1;
      3: asel_wr_i = 1'b1;
      default: cmp_wr_i = 1'b1;
    endcase
    @(negedge sys_clk_i);
    {dir_wr_i, port_wr_i, hold_wr_i, asel_wr_i, cmp_wr_i} = 5'h00;
  endtask

  task automatic check_all;
    logic [7:0] pm, an, eoe, eo, w, lvl, ck;
    int         m;
    m   = osc_mode_i;
    pm  = {m == 8 || m == 9, m == 5 || m == 7 || m == 8, 6'h3F};
    ck  = {1'b0, m == 4 || m == 6 || m == 9, 6'h00};
    an  = {2'b00, asel[4], 1'b0, asel[3:0] | {4{cmp != 3'h7}}};
    eoe = (~dir & pm & ~{5'h00, ref_en, 2'b00}) | ck;
    eo  = hold;
    if (r1 && !dir[4]) begin
      eo[4] = c1;
    end
    if (r2 && !dir[5]) begin
      eo[5] = c2;
    end
    w   = (eoe & eo) | (~eoe & brd);
    lvl = w & pm & ~an & ~{5'h00, ref_en, 2'b00};
    `CHK("dir", dir & pm, dir_o)
    `CHK("hold", hold & pm, hold_o)
    `CHK("levels", lvl, lvl_o)
    `CHK("asel", asel, asel_o)
    `CHK("cmp", cmp, cmp_o)
    `CHK("oe", eoe, oe_o)
    `CHK("pin", eo & eoe & ~ck, pin_o & eoe & ~ck)
    `CHK("t0", w[4], t0_o)
    `CHK("ss", w[5], ss_o)
    `CHK("analog", 6'(an | {5'h00, ref_en, 2'b00}), acon_o)
  endtask

  task automatic done(input string s);
    $display("test %s done, mismatches so far %0d", s, errors);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #400000;
    errors++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    cyc(7);
    check_all();
    done("reset");
    for (int m = 0; m < 10; m++) begin
      osc_mode_i = 4'(m);
      repeat (6) begin
        dir  = 8'($random(seed));
        hold = 8'($random(seed));
        asel = 5'($random(seed));
        cmp  = ($random(seed) & 1) ? 3'h7 : 3'($random(seed));
        brd  = 8'($random(seed));
        {ref_en, r1, r2, c1, c2} = 5'($random(seed));
        k = ($random(seed) & 1) ? 1 : 2;
        wr(0, dir);
        wr(k, hold);
        wr(3, {3'b000, asel});
        wr(4, {5'h00, cmp});
        cyc(6);
        check_all();
      end
    end
    done("random");
    dir = 8'hFF;
    wr(0, dir);
    cyc(6);
    brd[4] = ~brd[4];
    cyc(4);
    `CHK("sync4", ~brd[4], lvl_o[4])
    cyc(1);
    `CHK("sync5", brd[4], lvl_o[4])
    done("sync");
    osc_mode_i = 4'h4;
    cyc(3);
    hi = 4'h0;
    repeat (8) begin
      @(negedge sys_clk_i);
      hi = hi + {3'b000, pin_o[6]};
    end
    `CHK("clkout", 4'h4, hi)
    `CHK("clkout_oe", 1'b1, oe_o[6])
    done("clkout");
    rst_b_i = 1'b0;
    cyc(2);
    `CHK("oe_in_reset", 8'h00, oe_o)
    rst_b_i = 1'b1;
    {dir, hold, asel, cmp} = {8'hFF, 8'h00, 5'h1F, 3'h7};
    cyc(7);
    check_all();
    done("second reset");
    finish_test();
  end
endmodule // bidir_port_with_pin_sharing_bench
